/* verilog/qdac_ctrl.sv */
// Quad converter serial load control: shift register, channel registers, load and reset
//
// Behaviour
// - Serial input is sampled on falling serial clock edges only while a frame is shifting.
// - Frame starts on sync low; next 24 falling edges fill shift register.
// - Serial output changes on rising edge; receiver samples on next falling edge.
// - Serial output serves readback and daisy chaining.
// - Load pulse low copies pending input registers to converter registers together.
// - Load pin works asynchronously (pin) and synchronously (held low during frame).
// - Reset input acts on its falling edge.
// - While reset is low, load pulses are ignored.
// - Reset loads input and converter registers with zero or midscale per select pin.
// - Power-on sets all channels to zero or midscale per select pin.
// - Codes are straight binary, 0 to 65535 or 0 to 4095.
`timescale 1ns/1ns
`default_nettype none
module qdac_ctrl #(
    parameter bit TWELVE_BIT = 1'b0
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Serial link pins
    input wire logic serial_clk_i,
    input wire logic frame_sync_n_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    // Control pins
    input wire logic load_outputs_n_i,
    input wire logic reset_n_i,
    input wire logic reset_level_select_i,
    // Converter codes, straight binary
    output logic [63:0] dac_code_o,
    output logic [3:0] dac_update_o
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic sclk_rise, sclk_fall;
    logic sync_rise, sync_fall;
    logic serial_in_lvl, load_outputs_n_lvl, load_outputs_n_fall;
    logic rstn_lvl, rstn_rise, rstn_fall;
    logic rsel_lvl;

    qdac_sync u_sclk (.core_clk_i(core_clk_i), .rst_i(rst_i), .init_i(1'b0), .async_i(serial_clk_i),
        .level_o(), .rise_o(sclk_rise), .fall_o(sclk_fall));
    qdac_sync u_sync (.core_clk_i(core_clk_i), .rst_i(rst_i), .init_i(1'b1), .async_i(frame_sync_n_i),
        .level_o(), .rise_o(sync_rise), .fall_o(sync_fall));
    qdac_sync u_serial_in (.core_clk_i(core_clk_i), .rst_i(rst_i), .init_i(1'b0), .async_i(serial_in_i),
        .level_o(serial_in_lvl), .rise_o(), .fall_o());
    qdac_sync u_load_outputs_n (.core_clk_i(core_clk_i), .rst_i(rst_i), .init_i(1'b1), .async_i(load_outputs_n_i),
        .level_o(load_outputs_n_lvl), .rise_o(), .fall_o(load_outputs_n_fall));
    qdac_sync u_rstn (.core_clk_i(core_clk_i), .rst_i(rst_i), .init_i(1'b1), .async_i(reset_n_i),
        .level_o(rstn_lvl), .rise_o(rstn_rise), .fall_o(rstn_fall));
    qdac_sync u_rsel (.core_clk_i(core_clk_i), .rst_i(rst_i), .init_i(1'b0), .async_i(reset_level_select_i),
        .level_o(rsel_lvl), .rise_o(), .fall_o());

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        qdac_pkg::qdac_state_t state;
        logic [4:0] bit_cnt;
        logic [23:0] shift;
        logic [23:0] out_shift;
        logic serial_out;
        logic [3:0][15:0] in_reg;
        logic [3:0][15:0] dac_reg;
        logic [3:0] pending;
        logic [3:0] upd;
        logic [3:0] rb_sel;
        logic por_done;
        logic [1:0] por_cnt;
    } qdac_st_t;

    qdac_st_t r_reg;
    qdac_st_t r_next;

    function automatic logic [15:0] qdac_reset_code(input logic sel);
        qdac_reset_code = sel ? (TWELVE_BIT ? qdac_pkg::CODE_MID_12 : qdac_pkg::CODE_MID) : qdac_pkg::CODE_ZERO;
    endfunction

    function automatic logic [15:0] qdac_clip(input logic [15:0] code);
        qdac_clip = TWELVE_BIT ? (code & qdac_pkg::CODE_FULL_12) : code;
    endfunction

    logic [3:0] cmd_w;
    logic [3:0] addr_w;
    logic [15:0] code_w;
    logic [23:0] frame_w;
    logic load_req;

    always_comb begin
        r_next = r_reg;
        r_next.upd = 4'h0;
        frame_w = {r_reg.shift[22:0], serial_in_lvl};
        cmd_w = frame_w[qdac_pkg::CMD_MSB:qdac_pkg::CMD_LSB];
        addr_w = frame_w[qdac_pkg::ADDR_MSB:qdac_pkg::ADDR_LSB];
        code_w = qdac_clip(frame_w[15:0]);
        load_req = 1'b0;

        // Power-on: select level caught after the synchronisers settle
        if (!r_reg.por_done) begin
            r_next.por_cnt = r_reg.por_cnt + 2'h1;
            if (r_reg.por_cnt == qdac_pkg::POR_WAIT) begin
                r_next.por_done = 1'b1;
                for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
                    r_next.in_reg[i] = qdac_reset_code(rsel_lvl);
                    r_next.dac_reg[i] = qdac_reset_code(rsel_lvl);
                end
                r_next.pending = 4'h0;
            end
        end else if (rstn_fall) begin
            for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
                r_next.in_reg[i] = qdac_reset_code(rsel_lvl);
                r_next.dac_reg[i] = qdac_reset_code(rsel_lvl);
            end
            r_next.pending = 4'h0;
            r_next.upd = 4'hF;
        end else begin
            // Load first, so a write landing in the same cycle stays pending
            if (load_outputs_n_fall && rstn_lvl) begin
                load_req = 1'b1;
            end
            if (sync_rise && r_reg.state == qdac_pkg::QDAC_DONE && !load_outputs_n_lvl && rstn_lvl) begin
                load_req = 1'b1;
            end
            if (sync_rise && r_reg.state == qdac_pkg::QDAC_DONE
                && r_reg.shift[qdac_pkg::CMD_MSB:qdac_pkg::CMD_LSB] == qdac_pkg::CMD_UPDATE_FROM_INPUT) begin
                load_req = 1'b1;
            end
            if (load_req) begin
                for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
                    if (r_reg.pending[i]) begin
                        r_next.dac_reg[i] = r_reg.in_reg[i];
                        r_next.pending[i] = 1'b0;
                        r_next.upd[i] = 1'b1;
                    end
                end
            end

            // Frame control
            case (r_reg.state)
                qdac_pkg::QDAC_IDLE: begin
                    if (sync_fall) begin
                        r_next.state = qdac_pkg::QDAC_SHIFT;
                        r_next.bit_cnt = 5'h00;
                    end
                end
                qdac_pkg::QDAC_SHIFT: begin
                    if (sync_rise) begin
                        r_next.state = qdac_pkg::QDAC_IDLE;
                    end else if (sclk_fall) begin
                        r_next.shift = frame_w;
                        r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
                        if (r_reg.bit_cnt == qdac_pkg::FRAME_LAST) begin
                            r_next.state = qdac_pkg::QDAC_DONE;
                            case (cmd_w)
                                qdac_pkg::CMD_WRITE_INPUT, qdac_pkg::CMD_WRITE_UPDATE: begin
                                    for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
                                        if (addr_w[i]) begin
                                            r_next.in_reg[i] = code_w;
                                            r_next.pending[i] = 1'b1;
                                        end
                                    end
                                end
                                qdac_pkg::CMD_READBACK_SEL: r_next.rb_sel = addr_w;
                                default: ;
                            endcase
                        end
                    end
                end
                qdac_pkg::QDAC_DONE: begin
                    if (sync_rise) begin
                        r_next.state = qdac_pkg::QDAC_IDLE;
                    end
                end
                default: r_next.state = qdac_pkg::QDAC_IDLE;
            endcase

            // Serial output: chain the shifted frame, or readback after a select
            if (sync_fall) begin
                r_next.out_shift = r_reg.shift;
                for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
                    if (r_reg.rb_sel[i]) begin
                        r_next.out_shift = {8'h00, r_reg.in_reg[i]};
                    end
                end
                r_next.rb_sel = 4'h0;
            end else if (sclk_rise && r_reg.state == qdac_pkg::QDAC_SHIFT) begin
                r_next.serial_out = r_reg.out_shift[23];
                r_next.out_shift = {r_reg.out_shift[22:0], 1'b0};
            end

        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign serial_out_o = r_reg.serial_out;
    assign dac_update_o = r_reg.upd;
    generate
        for (genvar g = 0; g < 4; g++) begin : g_code
            assign dac_code_o[g*16 +: 16] = r_reg.dac_reg[g];
        end
    endgenerate

    // ****************************************
    // Checks
    // ****************************************
    a_reset_blocks_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (r_reg.por_done && !rstn_lvl && !rstn_fall && !rstn_rise) |=> (r_reg.upd == 4'h0))
        else $error("load while reset low");
    a_reset_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (r_reg.por_done && rstn_fall) |=> (r_reg.dac_reg[0] == qdac_reset_code($past(rsel_lvl))))
        else $error("reset code wrong");
    a_sdo_on_rise: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $changed(r_reg.serial_out) |-> $past(sclk_rise))
        else $error("serial out moved off rising edge");
    a_frame_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (r_reg.state == qdac_pkg::QDAC_DONE) |-> (r_reg.bit_cnt == 5'h18))
        else $error("frame length wrong");
    a_update_copies: assert property (@(posedge core_clk_i) disable iff (rst_i)
        r_reg.upd[1] && !$past(rstn_fall) |-> (r_reg.dac_reg[1] == $past(r_reg.in_reg[1])))
        else $error("update not from input register");
    a_shift_on_fall: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (r_reg.por_done && !rstn_fall && sclk_fall && !sync_rise && r_reg.state == qdac_pkg::QDAC_SHIFT)
        |=> (r_reg.shift == {$past(r_reg.shift[22:0]), $past(serial_in_lvl)}))
        else $error("serial input not shifted on falling edge");
endmodule
`default_nettype wire

/* inc/qdac_pkg.sv */
// Package of constants and types for the quad converter serial load control
package qdac_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CODE_BITS = 16;
    localparam int NUM_CH = 4;
    localparam int CH_BITS = 2;
    localparam int BIT_CNT_BITS = 5;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    // Cycles the power-on load waits for the select pin to clear its synchroniser
    localparam logic [1:0] POR_WAIT = 2'h2;
    // Frame layout: command [23:20], address [19:16], code [15:0]
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
    localparam logic [3:0] CMD_UPDATE_FROM_INPUT = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_READBACK_SEL = 4'h9;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;
    localparam logic [15:0] CODE_MID_12 = 16'h0800;
    localparam logic [15:0] CODE_FULL_16 = 16'hFFFF;
    localparam logic [15:0] CODE_FULL_12 = 16'h0FFF;

    typedef enum logic [1:0] {
        QDAC_IDLE = 2'b00,
        QDAC_SHIFT = 2'b01,
        QDAC_DONE = 2'b10
    } qdac_state_t;
endpackage

/* verilog/qdac_sync.sv */
// Two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ns
`default_nettype none
module qdac_sync (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic init_i,
    // Asynchronous level in
    input wire logic async_i,
    // Synchronised level and edges
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } qdac_sync_st_t;

    qdac_sync_st_t s_reg;
    qdac_sync_st_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.meta = async_i;
        s_next.sync = s_reg.meta;
        s_next.prev = s_reg.sync;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s_reg <= {init_i, init_i, init_i};
        end else begin
            s_reg <= s_next;
        end
    end

    // Before the first full history the stored level is the init value
    assign level_o = s_reg.sync;
    assign rise_o = s_reg.sync & ~s_reg.prev;
    assign fall_o = ~s_reg.sync & s_reg.prev;
endmodule
`default_nettype wire

/* bench/qdac_host.sv */
// Host serial port model: sends 24-bit frames and captures the serial output
`timescale 1ns/1ns
`default_nettype none
module qdac_host (
    // Clock
    input wire logic core_clk_i,
    // Link pins
    input wire logic serial_out_i,
    output logic serial_clk_o,
    output logic frame_sync_n_o,
    output logic serial_in_o
);
    // ****************************************
    // Framing, MSB first, 80 ns link period
    // ****************************************
    initial begin
        serial_clk_o = 1'b0;
        frame_sync_n_o = 1'b1;
        serial_in_o = 1'b0;
    end
    task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
        @(posedge core_clk_i);
        frame_sync_n_o <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        for (int i = 23; i >= 0; i--) begin
            serial_clk_o <= 1'b1;
            serial_in_o <= tx[i];
            repeat (5) @(posedge core_clk_i);
            serial_clk_o <= 1'b0;
            rx[i] = serial_out_i;
            repeat (5) @(posedge core_clk_i);
        end
        frame_sync_n_o <= 1'b1;
        // Released data line shows no stale bit
        serial_in_o <= ~tx[0];
        repeat (10) @(posedge core_clk_i);
    endtask
endmodule
`default_nettype wire

/* bench/tb_quad_dac_serial_load_control.sv */
// Self-checking bench of the quad converter serial load control
`timescale 1ns/1ns
`default_nettype none
module tb_quad_dac_serial_load_control;
    logic core_clk_i, rst_i, load_n, reset_n, sel, sclk, sync_n, sdi, serial_out, clr;
    logic [63:0] code;
    logic [3:0] upd, upd_seen, pend;
    logic [15:0] inp [4];
    logic [15:0] dac [4];
    logic [23:0] rx;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed;
    qdac_ctrl dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .serial_clk_i(sclk), .frame_sync_n_i(sync_n),
        .serial_in_i(sdi), .serial_out_o(serial_out), .load_outputs_n_i(load_n), .reset_n_i(reset_n),
        .reset_level_select_i(sel), .dac_code_o(code), .dac_update_o(upd));
    qdac_host host (.core_clk_i(core_clk_i), .serial_out_i(serial_out), .serial_clk_o(sclk),
        .frame_sync_n_o(sync_n), .serial_in_o(sdi));
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        upd_seen <= (clr || rst_i) ? 4'h0 : (upd_seen | upd);
        if (cycles == 10000) begin
            errors++;
            $display("[FAIL] run time expected below 10000 cycles seen %0d", cycles);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [63:0] expect_codes();
        return {dac[3], dac[2], dac[1], dac[0]};
    endfunction
    // Pending channels move to the converter side; returns the channels that strobe
    function automatic logic [3:0] apply();
        logic [3:0] chg;
        chg = pend;
        for (int c = 0; c < 4; c++) begin
            if (pend[c]) begin
                dac[c] = inp[c];
            end
        end
        pend = 4'h0;
        return chg;
    endfunction
    task automatic send(input logic [3:0] cmd, input logic [3:0] mask, input logic [15:0] val);
        host.frame({cmd, mask, val}, rx);
        for (int c = 0; c < 4; c++) begin
            if (cmd == qdac_pkg::CMD_WRITE_INPUT && mask[c]) begin
                inp[c] = val;
                pend[c] = 1'b1;
            end
        end
    endtask
    task automatic pulse_load();
        clr <= 1'b1;
        @(posedge core_clk_i);
        clr <= 1'b0;
        load_n <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        load_n <= 1'b1;
        repeat (8) @(posedge core_clk_i);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [3:0] chg;
        logic [23:0] w;
        int r;
        seed = 26316;
        rst_i = 1'b1;
        load_n = 1'b1;
        reset_n = 1'b1;
        sel = 1'b1;
        clr = 1'b0;
        pend = 4'h0;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        for (int c = 0; c < 4; c++) begin
            inp[c] = 16'h8000;
            dac[c] = 16'h8000;
        end
        check("power-on codes", code, expect_codes());
        $display("Test power-on done");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            send(qdac_pkg::CMD_WRITE_INPUT, (i == 0) ? 4'hF : r[3:0], (i == 0) ? 16'hFFFF : r[19:4]);
            check("staged codes", code, expect_codes());
            pulse_load();
            chg = apply();
            check("loaded codes", code, expect_codes());
            check("update strobes", {60'h0, upd_seen}, {60'h0, chg});
        end
        $display("Test staged load done");
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            w = {qdac_pkg::CMD_NOP, r[23:4]};
            send(qdac_pkg::CMD_READBACK_SEL, 4'h1 << k, r[15:0]);
            send(w[23:20], w[19:16], w[15:0]);
            check("readback word", {40'h0, rx}, {40'h0, 8'h00, inp[k]});
            send(qdac_pkg::CMD_NOP, 4'h0, 16'h0000);
            check("chained word", {40'h0, rx}, {40'h0, w});
        end
        $display("Test readback and chain done");
        load_n <= 1'b0;
        r = $random(seed);
        send(qdac_pkg::CMD_WRITE_INPUT, 4'h6, r[15:0]);
        repeat (8) @(posedge core_clk_i);
        chg = apply();
        check("tied load codes", code, expect_codes());
        load_n <= 1'b1;
        $display("Test tied load done");
        sel <= 1'b0;
        send(qdac_pkg::CMD_WRITE_INPUT, 4'hF, r[31:16]);
        reset_n <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        for (int c = 0; c < 4; c++) begin
            inp[c] = 16'h0000;
            dac[c] = 16'h0000;
        end
        pend = 4'h0;
        check("reset codes", code, expect_codes());
        send(qdac_pkg::CMD_READBACK_SEL, 4'h4, 16'h0000);
        send(qdac_pkg::CMD_NOP, 4'h0, 16'h0000);
        check("input cleared by reset", {40'h0, rx}, {40'h0, 8'h00, inp[2]});
        r = $random(seed);
        send(qdac_pkg::CMD_WRITE_INPUT, 4'h9, r[15:0]);
        pulse_load();
        check("load during reset", code, expect_codes());
        check("strobes during reset", {60'h0, upd_seen}, 64'h0);
        reset_n <= 1'b1;
        pulse_load();
        chg = apply();
        check("load after reset", code, expect_codes());
        check("strobes after reset", {60'h0, upd_seen}, {60'h0, chg});
        $display("Test reset pin done");
        end_sim();
    end
endmodule
`default_nettype wire
